// ==== inc/ssar_defs.svh ====
// constants for the stereo serial audio receiver
`ifndef SSAR_DEFS_SVH
`define SSAR_DEFS_SVH

// register offsets on the control port
`define SSAR_AUDIO_FORMAT_OFF 8'h04
`define SSAR_STATUS_OFF 8'h60
`define SSAR_AUDIO_FORMAT_RST 8'h05

// audio format codes held in the low nibble of the format register
`define SSAR_FMT_RA16 4'h0
`define SSAR_FMT_RA20 4'h1
`define SSAR_FMT_RA24 4'h2
`define SSAR_FMT_I2S16 4'h3
`define SSAR_FMT_I2S20 4'h4
`define SSAR_FMT_I2S24 4'h5
`define SSAR_FMT_LA16 4'h6
`define SSAR_FMT_LA20 4'h7
`define SSAR_FMT_LA24 4'h8

// word lengths and field layout
`define SSAR_LEN16 5'h10
`define SSAR_LEN20 5'h14
`define SSAR_LEN24 5'h18
`define SSAR_SAMPLE_W 24
`define SSAR_FMT_LSB 0
`define SSAR_FMT_MSB 3
`define SSAR_ST_OVF_BIT 0
`define SSAR_ST_AVAIL_BIT 1
`define SSAR_FIFO_DEPTH 16

`endif

// ==== inc/ssar_pkg.sv ====
// types shared by the stereo serial audio receiver
package ssar_pkg;

  // framing selected by the format register
  typedef enum logic [1:0] {
    SSAR_I2S = 2'b00,
    SSAR_LEFT_ALIGNED = 2'b01,
    SSAR_RIGHT_ALIGNED = 2'b10
  } ssar_framing_t;

  // decoded format: framing plus word length in bits
  typedef struct packed {
    ssar_framing_t framing;
    logic [4:0] len;
  } ssar_cfg_t;

  // one stereo frame, samples left aligned in 24 bits
  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } ssar_pair_t;

  // write strobe of the control port
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssar_reg_req_t;

endpackage : ssar_pkg

// ==== src/ssar_rx.sv ====
// stereo serial audio receiver: link deserialiser, crossings, fifo, format register
// Behaviour
// - 16, 20, 24 bit words, three framings
// - bit clock 32/48/64 fs shifts data
// - i2s: select low left, high right
// - i2s: msb one bit after select edge
// - msb first, captured on rising edge
// - i2s/left aligned: ignore trailing slot bits
// - aligned framings: select high left, low right
// - left aligned: msb with select edge
// - right aligned 24 bit: data eight bits late
// - right aligned: lsb just before select edge
// - right aligned: ignore leading slot bits
// - samples are signed two's complement

`include "ssar_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// plain flop fifo, width and depth set the storage
module ssar_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = `SSAR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_LVL = DEPTH[AW:0]; // fill level of a full store

  logic [WIDTH-1:0] mem_q [DEPTH]; // storage, indexed
  logic [AW-1:0] wr_q; // write index
  logic [AW-1:0] rd_q; // read index
  logic [AW:0] cnt_q; // fill level
  logic push;
  logic pop;

  // honest flags straight from the fill level
  assign in_ready = (cnt_q != FULL_LVL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
    end
  end

  // fill level
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : ssar_fifo

////////////////////////////////////////////////////////////////////////////////
// top: serial link on bit_clock, control and sample output on clk
module ssar_rx #(
  parameter int FIFO_DEPTH = `SSAR_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire ssar_pkg::ssar_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic bit_clock,
  input wire logic channel_select_clock,
  input wire logic serial_audio_in,
  output logic pair_valid,
  input wire logic pair_ready,
  output ssar_pkg::ssar_pair_t pair_data
);
  import ssar_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // control domain: format register and status

  logic [7:0] fmt_reg_q; // audio_format_config
  logic fmt_tgl_q; // flips on each format write
  logic ovf_q; // sticky: a frame was lost to a full fifo
  logic fmt_wr;
  logic st_wr;

  assign fmt_wr = reg_req.wr && (reg_req.addr == `SSAR_AUDIO_FORMAT_OFF);
  assign st_wr = reg_req.wr && (reg_req.addr == `SSAR_STATUS_OFF);

  // format register, software steers framing and length
  always_ff @(posedge clk) begin
    if (reset) begin
      fmt_reg_q <= `SSAR_AUDIO_FORMAT_RST;
      fmt_tgl_q <= 1'b0;
    end else if (fmt_wr) begin
      fmt_reg_q <= reg_req.wdata;
      fmt_tgl_q <= ~fmt_tgl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain reset and format crossing

  logic lrst1_q; // first stage, read only by the second
  logic lrst2_q; // link-domain reset
  logic ftg1_q; // format toggle, first stage
  logic ftg2_q;
  logic ftg3_q; // previous value for change detect
  logic [3:0] fmt_l_q; // format code as seen by the link

  // reset brought into the link domain two bit clocks late; it only moves while the bit clock runs
  always_ff @(posedge bit_clock) begin
    lrst1_q <= reset;
    lrst2_q <= lrst1_q;
  end

  // toggle handshake: the register is stable long before the toggle lands
  always_ff @(posedge bit_clock) begin
    if (lrst2_q) begin
      ftg1_q <= 1'b0;
      ftg2_q <= 1'b0;
      ftg3_q <= 1'b0;
      fmt_l_q <= 4'(`SSAR_AUDIO_FORMAT_RST); // code field of the reset value
    end else begin
      ftg1_q <= fmt_tgl_q;
      ftg2_q <= ftg1_q;
      ftg3_q <= ftg2_q;
      if (ftg2_q != ftg3_q) begin
        fmt_l_q <= fmt_reg_q[`SSAR_FMT_MSB:`SSAR_FMT_LSB];
      end
    end
  end

  // code to framing and length; unknown codes fall back to i2s 24 bit
  function automatic ssar_cfg_t decode(input logic [3:0] code);
    ssar_cfg_t c;
    c.framing = SSAR_I2S;
    c.len = `SSAR_LEN24;
    case (code)
      `SSAR_FMT_RA16: begin c.framing = SSAR_RIGHT_ALIGNED; c.len = `SSAR_LEN16; end
      `SSAR_FMT_RA20: begin c.framing = SSAR_RIGHT_ALIGNED; c.len = `SSAR_LEN20; end
      `SSAR_FMT_RA24: begin c.framing = SSAR_RIGHT_ALIGNED; c.len = `SSAR_LEN24; end
      `SSAR_FMT_I2S16: begin c.framing = SSAR_I2S; c.len = `SSAR_LEN16; end
      `SSAR_FMT_I2S20: begin c.framing = SSAR_I2S; c.len = `SSAR_LEN20; end
      `SSAR_FMT_LA16: begin c.framing = SSAR_LEFT_ALIGNED; c.len = `SSAR_LEN16; end
      `SSAR_FMT_LA20: begin c.framing = SSAR_LEFT_ALIGNED; c.len = `SSAR_LEN20; end
      `SSAR_FMT_LA24: begin c.framing = SSAR_LEFT_ALIGNED; c.len = `SSAR_LEN24; end
      default: begin c.framing = SSAR_I2S; c.len = `SSAR_LEN24; end
    endcase
    return c;
  endfunction : decode

  //////////////////////////////////////////////////////////////////////////////
  // link domain: deserialiser
  // select and data are launched by the source on this same clock, so
  // they are sampled directly, one bit per rising edge

  ssar_cfg_t cfg;
  logic ws_q; // select level at the previous edge
  logic chg_q; // select changed one edge ago
  logic [23:0] sr_q; // last 24 bits received
  logic [5:0] cnt_q; // bits taken in the current slot
  logic slot_left_q; // current slot carries the left channel
  logic chg; // select changes at this edge
  logic start; // this edge carries an msb
  logic [23:0] cur; // shift register including this bit
  logic emit; // a sample is complete at this edge
  logic emit_left;
  logic [23:0] word; // completed sample, left aligned

  assign cfg = decode(fmt_l_q);
  assign chg = (channel_select_clock != ws_q);
  assign cur = {sr_q[22:0], serial_audio_in}; // msb first
  // i2s msb comes one bit after the edge, left aligned msb with it
  assign start = (cfg.framing == SSAR_I2S) ? chg_q : chg;

  // completion and alignment of a sample
  always_comb begin
    emit = 1'b0;
    emit_left = 1'b0;
    word = '0;
    if (cfg.framing == SSAR_RIGHT_ALIGNED) begin
      // the slot ends at the select edge; its lsb was the bit before it
      emit = chg;
      emit_left = ws_q;
      // only the last len bits count, leading pad is dropped
      word = sr_q << (5'(`SSAR_SAMPLE_W) - cfg.len);
    end else if (cfg.len == 5'h01 ? start : (!start && cnt_q == {1'b0, cfg.len} - 6'h01)) begin
      // len-th bit of the slot; later bits are never looked at
      emit = 1'b1;
      emit_left = slot_left_q;
      word = cur << (5'(`SSAR_SAMPLE_W) - cfg.len);
    end
  end

  // shift every bit; history is the right aligned sample source
  always_ff @(posedge bit_clock) begin
    if (lrst2_q) begin
      sr_q <= '0;
      ws_q <= 1'b0;
      chg_q <= 1'b0;
    end else begin
      sr_q <= cur;
      ws_q <= channel_select_clock;
      chg_q <= chg;
    end
  end

  // slot bit counter and channel of the slot
  always_ff @(posedge bit_clock) begin
    if (lrst2_q) begin
      cnt_q <= '0;
      slot_left_q <= 1'b0;
    end else if (start) begin
      cnt_q <= 6'h01;
      // i2s: low is left; left aligned: high is left
      slot_left_q <= (cfg.framing == SSAR_I2S) ? ~channel_select_clock
                                               : channel_select_clock;
    end else if (cnt_q != '0 && cnt_q < {1'b0, cfg.len}) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: pair assembly, one pair per frame

  logic [23:0] left_hold_q; // left sample awaiting its right partner
  logic have_left_q;
  ssar_pair_t pair_l_q; // frame handed to the control domain
  logic pair_tgl_q; // flips once per completed frame

  // a right sample without a preceding left is dropped so pairs never skew
  always_ff @(posedge bit_clock) begin
    if (lrst2_q) begin
      left_hold_q <= '0;
      have_left_q <= 1'b0;
      pair_l_q <= '0;
      pair_tgl_q <= 1'b0;
    end else if (emit && emit_left) begin
      left_hold_q <= word;
      have_left_q <= 1'b1;
    end else if (emit && have_left_q) begin
      pair_l_q.left <= left_hold_q; // sign kept in bit 23
      pair_l_q.right <= word;
      pair_tgl_q <= ~pair_tgl_q;
      have_left_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control domain: frame crossing into the fifo

  logic ptg1_q; // first stage, read only by the second
  logic ptg2_q;
  logic ptg3_q;
  logic push_q; // one-cycle push request
  ssar_pair_t push_data_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  ssar_pair_t fifo_out_data;
  logic take;

  // a frame lasts at least 32 bit clocks, so pair_l_q is stable when sampled
  always_ff @(posedge clk) begin
    if (reset) begin
      ptg1_q <= 1'b0;
      ptg2_q <= 1'b0;
      ptg3_q <= 1'b0;
      push_q <= 1'b0;
      push_data_q <= '0;
    end else begin
      ptg1_q <= pair_tgl_q;
      ptg2_q <= ptg1_q;
      ptg3_q <= ptg2_q;
      push_q <= (ptg2_q != ptg3_q);
      if (ptg2_q != ptg3_q) begin
        push_data_q <= pair_l_q;
      end
    end
  end

  // overflow: the serial source cannot stall, so a full fifo loses the frame
  always_ff @(posedge clk) begin
    if (reset) begin
      ovf_q <= 1'b0;
    end else if (push_q && !fifo_in_ready) begin
      ovf_q <= 1'b1; // set beats a clear in the same cycle
    end else if (st_wr && reg_req.wdata[`SSAR_ST_OVF_BIT]) begin
      ovf_q <= 1'b0;
    end
  end

  ssar_fifo #(
    .WIDTH($bits(ssar_pair_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(fifo_out_valid),
    .out_ready(take),
    .out_data(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // output stage and register read-back, all outputs from flops

  // consumer back-pressure reaches the fifo through this stage
  assign take = !pair_valid || pair_ready;

  // registered sample output
  always_ff @(posedge clk) begin
    if (reset) begin
      pair_valid <= 1'b0;
      pair_data <= '0;
    end else if (take) begin
      pair_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        pair_data <= fifo_out_data;
      end
    end
  end

  // read data follows the address one cycle later
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      case (reg_req.addr)
        `SSAR_AUDIO_FORMAT_OFF: reg_rdata <= fmt_reg_q;
        `SSAR_STATUS_OFF: begin
          reg_rdata <= '0;
          reg_rdata[`SSAR_ST_OVF_BIT] <= ovf_q;
          reg_rdata[`SSAR_ST_AVAIL_BIT] <= fifo_out_valid | pair_valid;
        end
        default: reg_rdata <= '0;
      endcase
    end
  end
endmodule : ssar_rx

// ==== test/ssar_rx_props.sv ====
// concurrent checks on the ports of the stereo serial audio receiver
module ssar_rx_props #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire ssar_pkg::ssar_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic bit_clock,
  input wire logic channel_select_clock,
  input wire logic serial_audio_in,
  input wire logic pair_valid,
  input wire logic pair_ready,
  input wire ssar_pkg::ssar_pair_t pair_data
);
  import ssar_pkg::*;
  // everything here lives in the control clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // a pair offered but held back by the consumer
  sequence s_stalled;
    pair_valid && !pair_ready;
  endsequence
  // a format write, then quiet cycles looking at the same place
  sequence s_fmt_wr;
    reg_req.wr && reg_req.addr == 8'h04;
  endsequence
  sequence s_fmt_rd;
    !reg_req.wr && reg_req.addr == 8'h04;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  chk_hold_valid: assert property (s_stalled |=> pair_valid)
    else $error("pair withdrawn before it was taken");
  chk_hold_data: assert property (s_stalled |=> $stable(pair_data))
    else $error("pair data changed while stalled");
  chk_drop_taken: assert property ($fell(pair_valid) |-> $past(pair_ready))
    else $error("pair valid fell without a handshake");
  chk_fmt_readback: assert property (s_fmt_wr ##1 s_fmt_rd [*2] |-> reg_rdata == $past(reg_req.wdata, 2))
    else $error("format register does not read back the written value");
  chk_fmt_steady: assert property (s_fmt_rd [*3] |-> $stable(reg_rdata))
    else $error("format read back changed without a write");
  chk_fmt_reset: assert property ($fell(reset) && !reg_req.wr && reg_req.addr == 8'h04 |=> reg_rdata == 8'h05)
    else $error("format register reset value wrong");
  chk_unmapped_zero: assert property (!(reg_req.addr inside {8'h04, 8'h60}) |=> reg_rdata == 8'h00)
    else $error("unmapped address read back nonzero");
  chk_status_spare: assert property (reg_req.addr == 8'h60 |=> reg_rdata[7:2] == 6'h00)
    else $error("spare status bits set");
endmodule : ssar_rx_props

bind ssar_rx ssar_rx_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_ssar_rx_props (.clk(clk), .reset(reset),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .bit_clock(bit_clock),
  .channel_select_clock(channel_select_clock), .serial_audio_in(serial_audio_in),
  .pair_valid(pair_valid), .pair_ready(pair_ready), .pair_data(pair_data));

// ==== test/ssar_src.sv ====
// upstream audio source model driving the serial link
module ssar_src (
  output logic bit_clock,
  output logic channel_select_clock,
  output logic serial_audio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssar_pkg::*;
  // link clock stands low between bursts
  initial begin
    bit_clock = 1'b0;
    channel_select_clock = 1'b0;
    serial_audio_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one 12 ns bit: lines move while low, receiver samples at the rise
  task automatic tick(input logic sel, input logic dat);
    channel_select_clock = sel;
    serial_audio_in = dat;
    #6 bit_clock = 1'b1;
    #6 bit_clock = 1'b0;
  endtask : tick
  // free bits with a toggling data line, used while reset settles
  task automatic idle(input int n);
    repeat (n) tick(1'b0, ~serial_audio_in);
  endtask : idle
  // frames of left/right pairs, smp holds left in even and right in odd slots
  task automatic send_burst(input ssar_framing_t fr, input int len, input int slot,
                            input int nfr, input logic [23:0] smp[64]);
    logic lft;
    int p;
    int i;
    logic [23:0] s;
    lft = (fr == SSAR_I2S) ? 1'b0 : 1'b1;
    // prelude gives the format time to cross; right aligned stays on the left
    // level so the one-bit slot left by the last burst never pairs with it
    repeat (6) tick((fr == SSAR_RIGHT_ALIGNED) ? lft : ~lft, 1'b1);
    if (fr == SSAR_I2S) tick(lft, 1'b0); // select edge one bit ahead of msb
    for (int k = 0; k < 2 * slot * nfr; k++) begin
      p = k % slot;
      s = smp[k / slot];
      // right aligned: sample sits at the slot end, garbage before it
      i = (fr == SSAR_RIGHT_ALIGNED) ? p - (slot - len) : p;
      if (fr == SSAR_I2S) tick(((k + 1) / slot) % 2 ? ~lft : lft, (i < len) ? s[23-i] : k[0]);
      else tick((k / slot) % 2 ? ~lft : lft, (i >= 0 && i < len) ? s[23-i] : k[0]);
    end
    // the right slot of the right aligned framing ends only at the next edge
    if (fr == SSAR_RIGHT_ALIGNED) tick(lft, 1'b0);
    serial_audio_in = ~serial_audio_in; // released line shows no stale bit
  endtask : send_burst
endmodule : ssar_src

// ==== test/tb_ssar_rx.sv ====
// self-checking bench for the stereo serial audio receiver
module tb_ssar_rx;
  timeunit 1ns;
  timeprecision 1ps;
  import ssar_pkg::*;
  logic clk, reset, pair_ready, pair_valid, bit_clock, channel_select_clock, serial_audio_in;
  ssar_reg_req_t reg_req;
  logic [7:0] reg_rdata, rd;
  ssar_pair_t pair_data;
  ssar_pair_t got[$]; // pairs taken from the design
  logic [23:0] smp[64]; // samples handed to the source
  int n_fail, num_checks, cyc, seed;
  logic stall; // consumer held off
  logic [31:0] rnd;

  ssar_rx u_ssar_rx (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .bit_clock(bit_clock), .channel_select_clock(channel_select_clock),
    .serial_audio_in(serial_audio_in), .pair_valid(pair_valid), .pair_ready(pair_ready),
    .pair_data(pair_data));
  ssar_src u_ssar_src (.bit_clock(bit_clock), .channel_select_clock(channel_select_clock),
    .serial_audio_in(serial_audio_in));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz control clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // collect pairs, wander ready, cut a hang short
  always @(posedge clk) begin
    if (pair_valid === 1'b1 && pair_ready === 1'b1) got.push_back(pair_data);
    rnd = $random(seed);
    pair_ready <= !stall && rnd[0];
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // write strobe lasts exactly one clock
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{1'b1, a, d};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : reg_wr
  // read back is registered, so wait past the answer
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    reg_req <= '{1'b0, a, 8'h00};
    repeat (3) @(posedge clk);
    rd = reg_rdata;
  endtask : reg_rd
  // words shorter than 24 bits arrive with their low bits cleared
  function automatic logic [23:0] trim(input logic [23:0] s, input int n);
    return s & (24'hffffff << (24 - n));
  endfunction : trim
  // random samples with the two extremes up front
  task automatic fill(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      smp[i] = r[23:0];
    end
    smp[0] = 24'h800000;
    smp[1] = 24'h7fffff;
    got.delete();
  endtask : fill
  // one format code: program it, send frames at a random bit clock rate, compare
  task automatic run(input logic [3:0] c, input int nfr);
    int w;
    int len;
    int slot;
    logic [31:0] r;
    ssar_framing_t fr;
    fr = c < 3 ? SSAR_RIGHT_ALIGNED : (c < 6 ? SSAR_I2S : SSAR_LEFT_ALIGNED);
    len = 16 + 4 * (c % 3);
    r = $random(seed);
    slot = (len == 16 && r[1:0] == 2'b00) ? 16 : (r[2] ? 24 : 32); // 32, 48, 64 fs
    fill(2 * nfr);
    reg_wr(8'h04, {r[7:4], c});
    reg_rd(8'h04);
    check("format", {40'h0, rd}, {40'h0, r[7:4], c});
    u_ssar_src.send_burst(fr, len, slot, nfr, smp);
    w = 0;
    while (got.size() < nfr && w < 400) begin
      @(posedge clk);
      w++;
    end
    for (int i = 0; i < nfr; i++)
      check("pair", got[i], {trim(smp[2*i], len), trim(smp[2*i+1], len)});
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hcc90a497;
    reset = 1'b1;
    stall = 1'b0;
    pair_ready = 1'b0;
    reg_req = '{1'b0, 8'h04, 8'h00}; // format address across release
    // link reset needs bit clocks as well as control clocks
    fork
      repeat (4) @(posedge clk);
      u_ssar_src.idle(10);
    join
    @(posedge clk);
    reset <= 1'b0;
    reg_rd(8'h04);
    check("format reset", {40'h0, rd}, 48'h05);
    reg_rd(8'h3c);
    check("unmapped", {40'h0, rd}, 48'h00);
    for (int c = 0; c < 9; c++) run(c[3:0], 3);
    // overrun the fifo with the consumer stalled
    stall = 1'b1;
    fill(36);
    reg_wr(8'h04, 8'h03);
    u_ssar_src.send_burst(SSAR_I2S, 16, 16, 18, smp);
    // last frame still crossing into the control domain
    repeat (8) @(posedge clk);
    reg_rd(8'h60);
    check("status full", {40'h0, rd}, 48'h03);
    stall = 1'b0;
    repeat (300) @(posedge clk);
    // fifo plus the output register hold 17 frames, the 18th is lost
    for (int i = 0; i < 17; i++)
      check("drained", got[i], {trim(smp[2*i], 16), trim(smp[2*i+1], 16)});
    reg_rd(8'h60);
    check("status sticky", {40'h0, rd}, 48'h01);
    reg_wr(8'h60, 8'h01);
    reg_rd(8'h60);
    check("status clear", {40'h0, rd}, 48'h00);
    final_report();
  end
endmodule : tb_ssar_rx
